/* sif_core.sv */
/*
  serial interface core: wishbone registers, status flags, async and synchronous
  transmit and receive, request lines and dma request/acknowledge.
  assumes pins are asynchronous to clk; dma acks are one-cycle pulses on clk.
*/
// Our own choices: the register addresses and the Wishbone interface to the registers.
`include "sif_defines.svh"
module sif_core
  import sif_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dmaTxAck,
  input wire logic [7:0] dmaTxData,
  input wire logic dmaRxAck,
  output logic dmaTxReq,
  output logic dmaRxReq,
  output logic [7:0] dmaRxData,
  input wire logic rxdPin,
  output logic txdOut,
  output logic txdOe,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  output logic rxErrorIrq,
  output logic rxFullIrq,
  output logic txEmptyIrq,
  output logic txEndIrq,
  output logic [1:0] irqTop
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [10:0] ctrl;
    logic [7:0] baud;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic txe;
    logic rxf;
    logic ovr;
    logic framing_err_flag;
    logic per;
    logic tx_end_flag;
    logic [7:0] div;
    logic [3:0] ph;
    logic tick;
    sif_txst_t txSt;
    logic [7:0] txSh;
    logic [3:0] txBit;
    logic [3:0] txPh;
    logic txLine;
    logic txPar;
    sif_rxst_t rxSt;
    logic [7:0] rxSh;
    logic [3:0] rxBit;
    logic [3:0] rxPh;
    logic rxPar;
    logic rxdPrev;
    logic sckPrev;
    logic sckDrv;
    logic [3:0] lateCnt;
  } sif_core_st_t;

  sif_core_st_t st_reg;
  sif_core_st_t st_next;
  logic rxd;
  logic sck;
  logic rxErrAny;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  sif_sync uRxSync (.clk(clk), .nrst(nrst), .pinIn(rxdPin), .pinOut(rxd));
  sif_sync uSckSync (.clk(clk), .nrst(nrst), .pinIn(sckIn), .pinOut(sck));

  assign rxErrAny = st_reg.ovr | st_reg.framing_err_flag | st_reg.per;

  // ****************************************************************
  // request lines
  // ****************************************************************
  sif_irq_map uIrq (
    .txEmptyFlag(st_reg.txe),
    .rxFullFlag(st_reg.rxf),
    .rxErrAny(rxErrAny),
    .txEndFlag(st_reg.tx_end_flag),
    .txIrqEnable(st_reg.ctrl[`SIF_CTL_TIE]),
    .rxIrqEnable(st_reg.ctrl[`SIF_CTL_RIE]),
    .txEndIrqEnable(st_reg.ctrl[`SIF_CTL_TX_END_IRQ_ENABLE]),
    .rxErrorIrq(rxErrorIrq),
    .rxFullIrq(rxFullIrq),
    .txEmptyIrq(txEmptyIrq),
    .txEndIrq(txEndIrq),
    .irqTop(irqTop)
  ); // RULE_01

  // dma only on the full and empty requests; error and end never trigger it
  assign dmaTxReq = txEmptyIrq; // RULE_02
  assign dmaRxReq = rxFullIrq; // RULE_03
  assign dmaRxData = st_reg.rxBuf;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    logic wr, rd, te, re, sync, sckRise, sckFall, rxDone, rxFer, rxPer;
    wr = 1'b0;
    rd = 1'b0;
    sckRise = 1'b0;
    sckFall = 1'b0;
    rxDone = 1'b0;
    rxFer = 1'b0;
    rxPer = 1'b0;
    st_next = st_reg;
    te = st_reg.ctrl[`SIF_CTL_TE];
    re = st_reg.ctrl[`SIF_CTL_RE];
    sync = st_reg.ctrl[`SIF_CTL_SYNC];

    // wishbone slave: one wait state, ack drops the cycle after it is given
    wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_reg.ack && wb_sel_i[0];
    rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_reg.ack;
    st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
    if (rd) begin
      case (wb_adr_i)
        `SIF_OFS_CTRL: st_next.rdat = {21'h0, st_reg.ctrl};
        `SIF_OFS_STAT: st_next.rdat = {26'h0, st_reg.tx_end_flag, st_reg.per, st_reg.framing_err_flag,
                                       st_reg.ovr, st_reg.rxf, st_reg.txe};
        `SIF_OFS_TXBUF: st_next.rdat = {24'h0, st_reg.txBuf};
        `SIF_OFS_RXBUF: st_next.rdat = {24'h0, st_reg.rxBuf};
        `SIF_OFS_BAUD: st_next.rdat = {24'h0, st_reg.baud};
        default: st_next.rdat = 32'h0;
      endcase
    end

    // base clock divider: one tick every baud+1 system clocks
    st_next.tick = 1'b0;
    if (st_reg.div == st_reg.baud) begin
      st_next.div = 8'h00;
      st_next.tick = 1'b1;
      st_next.ph = st_reg.ph + 4'h1;
    end else begin
      st_next.div = st_reg.div + 8'h01;
    end

    // synchronous clock edges, from the pin or from our own driven clock
    if (st_reg.ctrl[`SIF_CTL_EXTCK]) begin
      sckRise = sck && !st_reg.sckPrev;
      sckFall = !sck && st_reg.sckPrev;
      st_next.sckPrev = sck;
    end else begin
      st_next.sckPrev = st_reg.sckDrv;
    end

    // ****************************************************************
    // transmitter
    // ****************************************************************
    case (st_reg.txSt)
      SIF_TX_IDLE: begin
        // synchronous transmit is held off by any receive error
        if (!st_reg.txe && !(sync && rxErrAny)) begin // RULE_12
          st_next.txSh = st_reg.txBuf;
          st_next.txe = 1'b1;
          st_next.tx_end_flag = 1'b0;
          st_next.txBit = 4'h0;
          st_next.txPh = st_reg.ph;
          st_next.txPar = st_reg.ctrl[`SIF_CTL_PARODD];
          st_next.txSt = sync ? SIF_TX_DATA : SIF_TX_START;
          st_next.txLine = sync ? st_reg.txLine : 1'b0;
        end
      end
      SIF_TX_START: begin
        if (st_reg.tick && st_reg.ph == st_reg.txPh) begin
          st_next.txLine = st_reg.txSh[0];
          st_next.txSt = SIF_TX_DATA;
        end
      end
      SIF_TX_DATA: begin
        if (sync) begin
          // internal clock: drive sck low then high each bit time
          if (!st_reg.ctrl[`SIF_CTL_EXTCK] && st_reg.tick) begin
            if (st_reg.ph == 4'h0) begin
              st_next.sckDrv = 1'b0;
              st_next.txLine = st_reg.txSh[0];
            end else if (st_reg.ph == 4'h8) begin
              st_next.sckDrv = 1'b1;
              sckRise = 1'b1;
            end
          end
          if (sckFall) begin
            st_next.txLine = st_reg.txSh[0];
          end
          if (sckRise) begin
            st_next.txSh = {1'b0, st_reg.txSh[7:1]};
            st_next.txBit = st_reg.txBit + 4'h1;
            if (st_reg.txBit == 4'h7) begin
              if (!st_reg.txe && !rxErrAny) begin
                st_next.txSh = st_reg.txBuf;
                st_next.txe = 1'b1;
                st_next.txBit = 4'h0;
              end else begin
                st_next.tx_end_flag = 1'b1; // RULE_21
                st_next.txSt = SIF_TX_IDLE;
              end
            end
          end
        end else if (st_reg.tick && st_reg.ph == st_reg.txPh) begin
          st_next.txPar = st_reg.txPar ^ st_reg.txSh[0];
          st_next.txSh = {1'b0, st_reg.txSh[7:1]};
          st_next.txBit = st_reg.txBit + 4'h1;
          if (st_reg.txBit == 4'h7) begin
            st_next.txLine = st_reg.ctrl[`SIF_CTL_PAREN] ?
                             (st_reg.txPar ^ st_reg.txSh[0]) : 1'b1;
            st_next.txSt = SIF_TX_STOP;
          end else begin
            st_next.txLine = st_reg.txSh[1];
          end
        end
      end
      SIF_TX_STOP: begin
        if (st_reg.tick && st_reg.ph == st_reg.txPh) begin
          st_next.txLine = 1'b1;
          if (st_reg.ctrl[`SIF_CTL_PAREN] && st_reg.txBit == 4'h8) begin
            st_next.txBit = 4'h9;
          end else begin
            st_next.txSt = SIF_TX_IDLE;
            if (st_reg.txe) begin
              st_next.tx_end_flag = 1'b1; // RULE_21
            end
          end
        end
      end
      default: st_next.txSt = SIF_TX_IDLE;
    endcase

    // ****************************************************************
    // receiver
    // ****************************************************************
    if (st_reg.tick) st_next.rxdPrev = rxd;
    if (st_reg.tick) begin
      st_next.rxPh = st_reg.rxPh + 4'h1;
    end
    case (st_reg.rxSt)
      SIF_RX_IDLE: begin
        st_next.lateCnt = 4'h0;
        if (re && sync) begin
          st_next.rxBit = 4'h0;
          st_next.rxSt = SIF_RX_DATA;
        end else if (re && st_reg.tick && !rxd && st_reg.rxdPrev) begin
          // falling start edge resyncs the base-clock phase
          st_next.rxPh = 4'h0; // RULE_14
          st_next.rxSt = SIF_RX_START;
        end
      end
      SIF_RX_START: begin
        if (st_reg.tick && st_reg.rxPh == `SIF_MID) begin
          // mid-bit check; phase runs on so bit 0 is taken a full bit later
          st_next.rxBit = 4'h0;
          st_next.rxPar = st_reg.ctrl[`SIF_CTL_PARODD];
          st_next.rxSt = rxd ? SIF_RX_IDLE : SIF_RX_DATA;
        end
      end
      SIF_RX_DATA: begin
        if (sync) begin
          if (sckRise) begin
            st_next.rxSh = {rxd, st_reg.rxSh[7:1]};
            st_next.rxBit = st_reg.rxBit + 4'h1;
            if (st_reg.rxBit == 4'h7) begin
              rxDone = 1'b1;
            end
          end
        end else if (st_reg.tick && st_reg.rxPh == `SIF_MID) begin
          st_next.rxSh = {rxd, st_reg.rxSh[7:1]}; // RULE_15
          st_next.rxPar = st_reg.rxPar ^ rxd;
          st_next.rxBit = st_reg.rxBit + 4'h1;
          if (st_reg.rxBit == 4'h7) begin
            st_next.rxSt = SIF_RX_STOP;
          end
        end
      end
      SIF_RX_STOP: begin
        if (st_reg.tick && st_reg.rxPh == `SIF_MID) begin
          if (st_reg.ctrl[`SIF_CTL_PAREN] && st_reg.rxBit == 4'h8) begin
            rxPer = (st_reg.rxPar ^ rxd);
            st_next.per = st_reg.per | rxPer;
            st_next.rxBit = 4'h9;
          end else begin
            // a break sets the framing error once; the receiver then idles until a new start edge
            rxFer = !rxd; // RULE_10
            rxDone = 1'b1;
          end
        end
      end
      default: st_next.rxSt = SIF_RX_IDLE;
    endcase

    if (rxDone) begin
      st_next.rxSt = (sync && re) ? SIF_RX_DATA : SIF_RX_IDLE;
      st_next.rxBit = 4'h0;
      st_next.lateCnt = 4'h1;
      if (st_reg.rxf) begin
        st_next.ovr = 1'b1; // RULE_08
        st_next.framing_err_flag = st_reg.framing_err_flag | rxFer;
      end else begin
        st_next.rxBuf = st_next.rxSh; // RULE_09
        st_next.framing_err_flag = st_reg.framing_err_flag | rxFer;
        st_next.rxf = !(rxFer || st_reg.per || rxErrAny);
      end
    end else if (st_reg.lateCnt != 4'h0 && st_reg.lateCnt != 4'hF) begin
      st_next.lateCnt = st_reg.lateCnt + 4'h1;
    end

    // ****************************************************************
    // software writes; hardware sets win over status-register clears
    // ****************************************************************
    if (wr) begin
      case (wb_adr_i)
        `SIF_OFS_CTRL: st_next.ctrl = wb_dat_i[10:0];
        `SIF_OFS_TXBUF: begin
          st_next.txBuf = wb_dat_i[7:0]; // RULE_07
          st_next.txe = 1'b0;
        end
        `SIF_OFS_STAT: begin
          // write zero to clear; a hardware set this cycle wins
          if (!wb_dat_i[`SIF_ST_RXF] && !rxDone) st_next.rxf = 1'b0;
          if (!wb_dat_i[`SIF_ST_OVR] && !rxDone) st_next.ovr = 1'b0;
          if (!wb_dat_i[`SIF_ST_FER] && !rxDone) st_next.framing_err_flag = 1'b0;
          if (!wb_dat_i[`SIF_ST_PER] && !rxPer) st_next.per = 1'b0;
          if (!wb_dat_i[`SIF_ST_TX_END_FLAG] && st_next.tx_end_flag == st_reg.tx_end_flag) st_next.tx_end_flag = 1'b0;
        end
        `SIF_OFS_BAUD: st_next.baud = wb_dat_i[7:0];
        default: st_next.baud = st_reg.baud;
      endcase
    end

    // dma transfers clear their flags automatically
    if (dmaTxAck) begin
      st_next.txBuf = dmaTxData; // RULE_07
      st_next.txe = 1'b0; // RULE_02
    end
    if (dmaRxAck && !rxDone) begin
      st_next.rxf = 1'b0; // RULE_03
    end

    // late receive disable in synchronous mode raises rx-full without a load
    if (sync && st_reg.ctrl[`SIF_CTL_RE] && wr && wb_adr_i == `SIF_OFS_CTRL
        && !wb_dat_i[`SIF_CTL_RE] && st_reg.lateCnt != 4'h0
        && st_reg.lateCnt <= `SIF_TICKS_SYNC_LATE) begin
      st_next.rxf = 1'b1; // RULE_19 RULE_20
    end

    // receive disable stops the receiver; error flags stay as they are
    if (!st_next.ctrl[`SIF_CTL_RE]) begin
      st_next.rxSt = SIF_RX_IDLE; // RULE_13
    end

    // transmit disable resets the transmitter at once from any state
    if (!st_next.ctrl[`SIF_CTL_TE]) begin
      st_next.txSt = SIF_TX_IDLE; // RULE_11
      st_next.txe = 1'b1;
      st_next.tx_end_flag = 1'b1;
      st_next.txLine = 1'b1;
      st_next.sckDrv = 1'b1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.ctrl <= `SIF_CTRL_RST;
      st_reg.baud <= `SIF_BAUD_RST;
      st_reg.txe <= 1'b1;
      st_reg.tx_end_flag <= 1'b1;
      st_reg.txLine <= 1'b1;
      st_reg.rxdPrev <= 1'b1;
      st_reg.sckPrev <= 1'b1;
      st_reg.sckDrv <= 1'b1;
      st_reg.txSt <= SIF_TX_IDLE;
      st_reg.rxSt <= SIF_RX_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs; with transmit off the pin follows the port bits
  // ****************************************************************
  assign wb_ack_o = st_reg.ack;
  assign wb_dat_o = st_reg.rdat;
  assign txdOut = st_reg.ctrl[`SIF_CTL_TE] ? st_reg.txLine // RULE_11
    : st_reg.ctrl[`SIF_CTL_PORTD];
  assign txdOe = st_reg.ctrl[`SIF_CTL_TE] | st_reg.ctrl[`SIF_CTL_PORTOE];
  assign sckOut = st_reg.sckDrv;
  assign sckOe = st_reg.ctrl[`SIF_CTL_SYNC] & ~st_reg.ctrl[`SIF_CTL_EXTCK];
endmodule : sif_core

/* sif_core_sva.sv */
/* checker of the serial core ports: requests, priority, dma levels, bus answer.
   assumes a bind onto sif_core, one clock domain. */
module sif_core_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic dmaTxReq,
  input wire logic dmaRxReq,
  input wire logic rxErrorIrq,
  input wire logic rxFullIrq,
  input wire logic txEmptyIrq,
  input wire logic txEndIrq,
  input wire logic [1:0] irqTop
);
  // ****************************************************************
  // properties
  // ****************************************************************
  // one domain only, so clock and reset are stated once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_TX_DMA: assert property (dmaTxReq == txEmptyIrq) else $error("tx dma req");
  AST_RX_DMA: assert property (dmaRxReq == rxFullIrq) else $error("rx dma req");
  AST_ERR_NODMA: assert property ($rose(rxErrorIrq) && !rxFullIrq |-> !dmaRxReq)
    else $error("error request reached dma");
  AST_PRIO_ERR: assert property (rxErrorIrq |-> irqTop == 2'h0) else $error("top err");
  AST_PRIO_FULL: assert property (!rxErrorIrq && rxFullIrq |-> irqTop == 2'h1)
    else $error("top full");
  AST_PRIO_EMPTY: assert property (!rxErrorIrq && !rxFullIrq && txEmptyIrq
    |-> irqTop == 2'h2) else $error("top empty");
  AST_PRIO_END: assert property (!rxErrorIrq && !rxFullIrq && !txEmptyIrq
    |-> irqTop == 2'h3) else $error("top end");
  // answer exactly one cycle after the request is taken
  AST_ACK_TAKEN: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule : sif_core_sva

bind sif_core sif_core_sva i_sva (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq),
  .rxErrorIrq(rxErrorIrq), .rxFullIrq(rxFullIrq), .txEmptyIrq(txEmptyIrq),
  .txEndIrq(txEndIrq), .irqTop(irqTop));

/* sif_defines.svh */
/*
  constants of the serial interrupt, status and receive-sampling block: register offsets,
  field positions, reset values and timing counts.
  assumes inclusion by bare name from the core and the testbench.
*/
// How it works
// [RULE_01] four requests per channel, each on its own line, each gated by its enable
// [RULE_02] tx-empty request follows flag; dma write to tx buffer clears flag
// [RULE_03] rx-full request follows flag; dma read of rx buffer clears flag
// [RULE_04] rx-error request on overrun, parity or framing flag; never a dma trigger
// [RULE_05] tx-end request on tx-end flag; never a dma trigger
// [RULE_06] priority: rx error, rx full, tx empty, tx end lowest
// [RULE_07] tx buffer writes always accepted; unsent pending byte is overwritten
// [RULE_08] overrun sets overrun flag, keeps rx-full at one, no buffer load
// [RULE_09] framing or parity error alone sets flags, loads buffer, rx-full stays zero
// [RULE_10] receiver keeps running during break, framing flag sets again; here it sets once, then the receiver idles until a new falling edge
// [RULE_11] clearing transmit enable resets transmitter, hands pin back to port control
// [RULE_12] synchronous mode: no transmit start while any receive error flag is set
// [RULE_13] clearing receive enable leaves error flags unchanged
// [RULE_14] async receive on sixteen-times base clock, synced to start-bit falling edge
// [RULE_15] async bit captured on eighth base-clock pulse after bit boundary
// [RULE_16] external party waits five system clocks after dma write before clocking
// [RULE_17] dma channel must select rx-full request as its source
// [RULE_18] external clock mode: enables set only with clock high, four clocks after rise
// [RULE_19] external clock: late receive disable sets rx-full without loading buffer
// [RULE_20] internal clock: late receive disable sets rx-full without loading buffer
// [RULE_21] last bit with nothing pending sets tx-end flag, pin holds last level
// [RULE_22] rx interrupt enable gates both rx-error and rx-full requests
// [RULE_23] requests are levels held while flag and enable are both one
`ifndef SIF_DEFINES_SVH
`define SIF_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SIF_OFS_CTRL 8'h00
`define SIF_OFS_STAT 8'h04
`define SIF_OFS_TXBUF 8'h08
`define SIF_OFS_RXBUF 8'h0C
`define SIF_OFS_BAUD 8'h10

// ****************************************************************
// control register fields
// ****************************************************************
`define SIF_CTL_TE 0
`define SIF_CTL_RE 1
`define SIF_CTL_TIE 2
`define SIF_CTL_RIE 3
`define SIF_CTL_TX_END_IRQ_ENABLE 4
`define SIF_CTL_SYNC 5
`define SIF_CTL_EXTCK 6
`define SIF_CTL_PAREN 7
`define SIF_CTL_PARODD 8
`define SIF_CTL_PORTD 9
`define SIF_CTL_PORTOE 10

// ****************************************************************
// status register fields
// ****************************************************************
`define SIF_ST_TXE 0
`define SIF_ST_RXF 1
`define SIF_ST_OVR 2
`define SIF_ST_FER 3
`define SIF_ST_PER 4
`define SIF_ST_TX_END_FLAG 5

// ****************************************************************
// reset values and timing
// ****************************************************************
`define SIF_CTRL_RST 11'h600
`define SIF_BAUD_RST 8'h03
`define SIF_OVS 5'h10
`define SIF_MID 4'h7
`define SIF_TICKS_SYNC_LATE 4'h3

`endif

/* sif_irq_map.sv */
/*
  request gating and priority encoding for the four serial requests.
  assumes flags and enables come from registers on the same clock.
*/
module sif_irq_map (
  input wire logic txEmptyFlag,
  input wire logic rxFullFlag,
  input wire logic rxErrAny,
  input wire logic txEndFlag,
  input wire logic txIrqEnable,
  input wire logic rxIrqEnable,
  input wire logic txEndIrqEnable,
  output logic rxErrorIrq,
  output logic rxFullIrq,
  output logic txEmptyIrq,
  output logic txEndIrq,
  output logic [1:0] irqTop
);
  // ****************************************************************
  // level requests, one line each
  // ****************************************************************
  assign rxErrorIrq = rxErrAny & rxIrqEnable; // RULE_04
  assign rxFullIrq = rxFullFlag & rxIrqEnable; // RULE_22
  assign txEmptyIrq = txEmptyFlag & txIrqEnable; // RULE_02
  assign txEndIrq = txEndFlag & txEndIrqEnable; // RULE_05 RULE_23

  // highest pending request: 0 err, 1 full, 2 empty, 3 end
  always_comb begin
    if (rxErrorIrq) begin
      irqTop = 2'h0; // RULE_06
    end else if (rxFullIrq) begin
      irqTop = 2'h1;
    end else if (txEmptyIrq) begin
      irqTop = 2'h2;
    end else begin
      irqTop = 2'h3;
    end
  end
endmodule : sif_irq_map

/* sif_link_model.sv */
/* remote serial party: async frames, synchronous clocked frames, async receiver.
   assumes the core's baud reset value, so one bit lasts BitNs. */
module sif_link_model #(
  parameter int BitNs = 1280
) (
  output logic rxd,
  output logic sck,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // line drivers
  // ****************************************************************
  // idle mark; clock stands high outside frames
  initial begin
    rxd = 1'b1;
    sck = 1'b1;
  end
  // async frame, lsb first; stopBit 0 forces a framing error
  task automatic send(input logic [7:0] d, input logic stopBit);
    rxd = 1'b0;
    #BitNs;
    for (int i = 0; i < 8; i++) begin
      rxd = d[i];
      #BitNs;
    end
    rxd = stopBit;
    #BitNs;
    rxd = 1'b1;
  endtask : send
  // data moves on the fall, so it is steady at the rise
  task automatic syncSend(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      sck = 1'b0;
      rxd = d[i];
      #80;
      sck = 1'b1;
      #80;
    end
    rxd = 1'b1;
  endtask : syncSend
  // mid-bit sampling of the core's transmit pin
  task automatic recv(output logic [7:0] d);
    @(negedge txd);
    #(BitNs + BitNs / 2);
    for (int i = 0; i < 8; i++) begin
      d[i] = txd;
      #BitNs;
    end
  endtask : recv
endmodule : sif_link_model

/* sif_pkg.sv */
/*
  types shared by the serial block: state enums.
  assumes sif_defines.svh is available for inclusion.
*/
package sif_pkg;
  typedef enum logic [1:0] {SIF_RX_IDLE, SIF_RX_START, SIF_RX_DATA, SIF_RX_STOP} sif_rxst_t;
  typedef enum logic [1:0] {SIF_TX_IDLE, SIF_TX_START, SIF_TX_DATA, SIF_TX_STOP} sif_txst_t;
endpackage : sif_pkg

/* sif_sync.sv */
/*
  three-stage synchroniser for a pin input; the output changes once stages two and
  three agree.
  assumes a single clock domain on clk and a synchronous active-low reset.
*/
module sif_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pinIn,
  output logic pinOut
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sif_sync_st_t;

  sif_sync_st_t st_reg;
  sif_sync_st_t st_next;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pinIn;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // agreement filter keeps a metastable stage two from toggling the output
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  // idle lines are high, so reset to mark level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_reg <= 4'hF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinOut = st_reg.q;
endmodule : sif_sync

/* test_serial_irq_status_logic.sv */
/* bench of the serial core: requests, flags, dma, async and sync frames.
   assumes sif_core, the link model and the checker are compiled first. */
`include "sif_defines.svh"
module test_serial_irq_status_logic;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // stimulus and checks
  // ****************************************************************
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00, txData = 8'h00, rxData, b, got;
  logic [31:0] dat = 32'h0, q, rdata;
  logic dmaTxAck = 1'b0, dmaRxAck = 1'b0, txReq, rxReq, rxd, sck, txd, txdOe;
  logic eIrq, fIrq, xIrq, nIrq;
  logic [1:0] top;
  int errors = 0, numChecks = 0;
  always #10 clk = ~clk;
  sif_core i_sif_core (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack),
    .dmaTxAck(dmaTxAck), .dmaTxData(txData), .dmaRxAck(dmaRxAck), .dmaTxReq(txReq),
    .dmaRxReq(rxReq), .dmaRxData(rxData), .rxdPin(rxd), .txdOut(txd), .txdOe(txdOe),
    .sckIn(sck), .sckOut(), .sckOe(), .rxErrorIrq(eIrq), .rxFullIrq(fIrq),
    .txEmptyIrq(xIrq), .txEndIrq(nIrq), .irqTop(top));
  sif_link_model i_sif_link_model (.rxd(rxd), .sck(sck), .txd(txd));
  // priority code worked out from the four request levels
  function automatic logic [31:0] expIrq(input logic [3:0] v);
    return {26'h0, v[3] ? 2'h0 : v[2] ? 2'h1 : v[1] ? 2'h2 : 2'h3, v};
  endfunction : expIrq
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic pulse(input logic tx);
    @(posedge clk);
    if (tx) dmaTxAck <= 1'b1; else dmaRxAck <= 1'b1;
    @(posedge clk);
    dmaTxAck <= 1'b0;
    dmaRxAck <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic stopTest;
    $display("checks %0d errors %0d", numChecks, errors);
    if (errors == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stopTest
  // watchdog: all frames together take well under this
  initial begin
    #1ms;
    errors++;
    stopTest();
  end
  initial begin
    void'($urandom(32'hC2F9));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    wb(0, `SIF_OFS_STAT, 0);
    check("status", 32'h21, q);
    wb(0, 8'h40, 32'h0);
    check("unmapped", 32'h0, q);
    wb(1, `SIF_OFS_CTRL, 32'h614);
    check("irqs", expIrq(4'h3), {26'h0, top, eIrq, fIrq, xIrq, nIrq});
    wb(1, `SIF_OFS_CTRL, 32'h610);
    check("irqs", expIrq(4'h1), {26'h0, top, eIrq, fIrq, xIrq, nIrq});
    $display("test irq gating done");
    wb(1, `SIF_OFS_CTRL, 32'h60A);
    b = 8'($urandom);
    i_sif_link_model.send(b, 1'b1);
    wait (fIrq === 1'b1) @(negedge clk);
    check("rx data", {24'h0, b}, {24'h0, rxData});
    check("irqs", expIrq(4'h4), {26'h0, top, eIrq, fIrq, xIrq, nIrq});
    check("rx dma req", 32'h1, {31'h0, rxReq});
    pulse(1'b0);
    check("full cleared", 32'h0, {31'h0, fIrq});
    $display("test async receive done");
    i_sif_link_model.send(b, 1'b1);
    i_sif_link_model.send(~b, 1'b1);
    wait (eIrq === 1'b1) @(negedge clk);
    check("kept data", {24'h0, b}, {24'h0, rxData});
    check("irqs", expIrq(4'hC), {26'h0, top, eIrq, fIrq, xIrq, nIrq});
    wb(1, `SIF_OFS_CTRL, 32'h608);
    wb(0, `SIF_OFS_STAT, 0);
    check("overrun flags", 32'h06, q & 32'h1E);
    wb(1, `SIF_OFS_STAT, 0);
    wb(1, `SIF_OFS_CTRL, 32'h60A);
    b = 8'($urandom);
    i_sif_link_model.send(b, 1'b0);
    wait (eIrq === 1'b1) @(negedge clk);
    wb(0, `SIF_OFS_STAT, 0);
    check("framing flags", 32'h08, q & 32'h1E);
    check("framed data", {24'h0, b}, {24'h0, rxData});
    wb(1, `SIF_OFS_STAT, 0);
    $display("test receive errors done");
    wb(1, `SIF_OFS_CTRL, 32'h66A);
    b = 8'($urandom);
    i_sif_link_model.syncSend(b);
    wait (fIrq === 1'b1) @(negedge clk);
    check("sync data", {24'h0, b}, {24'h0, rxData});
    pulse(1'b0);
    $display("test sync receive done");
    wb(1, `SIF_OFS_CTRL, 32'h615);
    check("tx dma req", 32'h1, {31'h0, txReq});
    txData <= 8'($urandom);
    fork
      i_sif_link_model.recv(got);
      pulse(1'b1);
    join
    check("tx byte", {24'h0, txData}, {24'h0, got});
    wait (nIrq === 1'b1) @(negedge clk);
    check("irqs", expIrq(4'h3), {26'h0, top, eIrq, fIrq, xIrq, nIrq});
    wb(1, `SIF_OFS_CTRL, 32'h400);
    check("port pin", 32'h1, {30'h0, txd, txdOe});
    $display("test transmit done");
    stopTest();
  end
endmodule : test_serial_irq_status_logic
